// ---- rtl/one_shot_pulse_timer.sv ----
// Operation
// - count from f1, f2, f8 or neighbour underflow
// - count down from programmed primary period
// - underflow reloads counters and clears start bit on the same edge
// - any stop reloads counters before resting
// - pulse lasts (n+1)(m+1) source cycles
// - trigger during count ignored, irq still raised
// - stop on underflow reload, flag or bit clear
// - timer irq half source cycle after underflow, one clock for f1 and neighbour
// - counter reads return live count
// - counter writes only touch reload registers
// - new period applies from next pulse
// - trigger enable routes pin, polarity picks edge
// - trigger disabled means pin never triggers
// - output pin carries pulse in this mode
// - secondary period register unused here
// - mode bits b5 b4 equal 1 0 select one-shot
// - level select 0 high pulse, 1 low pulse
`timescale 1ns/1ns
module one_shot_pulse_timer
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic neighbour_uf_in,
  input wire logic ext_irq_pin_in,
  output logic [7:0] rdata_out,
  output logic pulse_out_pin_out,
  output logic timer_irq_out,
  output logic ext_irq_out
);
  // bundled register request
  oneshot_pkg::reg_req_t req;
  // synchronised reset
  logic rst_meta_q;
  logic rstn_q;
  // registers
  logic [7:0] mode_q;
  logic [7:0] pmode_q;
  logic [7:0] presc_rld_q;
  logic [7:0] prim_rld_q;
  logic [7:0] sec_q;
  logic start_bit_q;
  logic pin_en_q;
  logic [1:0] src_q;
  // live counters
  logic [7:0] presc_q;
  logic [7:0] prim_q;
  logic running_q;
  // source dividers and tick
  logic [2:0] div_q;
  logic tick;
  // pin synchroniser, three stages
  logic [2:0] pin_sync_q;
  logic pin_level_q;
  // half-cycle irq delay
  logic irq_pend_q;
  logic [2:0] half_q;
  logic [2:0] half_target;
  logic underflow;
  logic mode_ok;
  logic trig_edge;
  logic sw_start;
  logic stop_req;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // read decode used by the read path
  function automatic logic [7:0] rd_mux(input logic [2:0] a, input logic [7:0] m,
    input logic [7:0] p, input logic [7:0] ps, input logic [7:0] pr,
    input logic [7:0] s, input logic st, input logic pe, input logic [1:0] sr);
    unique case (a)
      oneshot_pkg::ADDR_MODE: rd_mux = m;
      oneshot_pkg::ADDR_PULSE_MODE: rd_mux = p;
      oneshot_pkg::ADDR_PRESCALER: rd_mux = ps;
      oneshot_pkg::ADDR_PRIMARY: rd_mux = pr;
      oneshot_pkg::ADDR_SECONDARY: rd_mux = s;
      oneshot_pkg::ADDR_ONESHOT_CTRL: rd_mux = {7'h00, st};
      oneshot_pkg::ADDR_IRQ_PIN_EN: rd_mux = {7'h00, pe};
      oneshot_pkg::ADDR_CLK_SEL: rd_mux = {6'h00, sr};
    endcase
  endfunction

  // reset release through two flops
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta_q <= 1'b0;
      rstn_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rstn_q <= rst_meta_q;
    end
  end

  // one-shot mode decode from b5 b4
  assign mode_ok = {mode_q[oneshot_pkg::MODE_HI_POS], mode_q[oneshot_pkg::MODE_LO_POS]}
    == oneshot_pkg::MODE_ONESHOT;

  // count source tick; divider free-runs
  always_ff @(posedge clk_in or negedge rstn_q)
  begin
    if (!rstn_q)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  always_comb
  begin
    unique case (oneshot_pkg::src_sel_t'(src_q))
      oneshot_pkg::SRC_F1: tick = 1'b1;
      oneshot_pkg::SRC_F2: tick = div_q[0];
      oneshot_pkg::SRC_F8: tick = (div_q == 3'h7);
      oneshot_pkg::SRC_NEIGHBOUR: tick = neighbour_uf_in;
    endcase
  end

  // half a source cycle in clk cycles; neighbour and f1 use one cycle
  always_comb
  begin
    unique case (oneshot_pkg::src_sel_t'(src_q))
      oneshot_pkg::SRC_F8: half_target = 3'h4;
      default: half_target = 3'h1;
    endcase
  end

  // pin synchroniser: change counts when stages two and three agree
  always_ff @(posedge clk_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      pin_sync_q <= 3'h7; // pin rests high on its pull-up, so no false edge
      pin_level_q <= 1'b1;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[1:0], ext_irq_pin_in};
      if (pin_sync_q[1] == pin_sync_q[2])
        pin_level_q <= pin_sync_q[2];
    end
  end

  // active edge chosen by polarity, only when pin input enabled
  always_comb
  begin
    if (pmode_q[oneshot_pkg::TRIG_POL_POS])
      trig_edge = pin_en_q && !pin_sync_q[2] && pin_sync_q[1] == pin_sync_q[2]
        && pin_level_q;
    else
      trig_edge = pin_en_q && pin_sync_q[2] && pin_sync_q[1] == pin_sync_q[2]
        && !pin_level_q;
  end

  // ordinary pin interrupt, raised even while counting
  always_ff @(posedge clk_in or negedge rstn_q)
  begin
    if (!rstn_q)
      ext_irq_out <= 1'b0;
    else
      ext_irq_out <= trig_edge;
  end

  assign sw_start = req.wr && req.addr == oneshot_pkg::ADDR_ONESHOT_CTRL
    && req.wdata[oneshot_pkg::ONESHOT_START_POS];
  assign underflow = running_q && tick && presc_q == 8'h00 && prim_q == 8'h00;
  // stop by clearing start flag or start bit
  assign stop_req = !mode_q[oneshot_pkg::START_FLAG_POS] || !start_bit_q;

  // software registers; writes to counters only hit reload copies
  always_ff @(posedge clk_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      mode_q <= oneshot_pkg::RESET_BYTE;
      pmode_q <= oneshot_pkg::RESET_BYTE;
      presc_rld_q <= oneshot_pkg::RESET_COUNT;
      prim_rld_q <= oneshot_pkg::RESET_COUNT;
      sec_q <= oneshot_pkg::RESET_COUNT;
      pin_en_q <= 1'b0;
      src_q <= oneshot_pkg::RESET_SRC;
    end
    else if (req.wr)
    begin
      unique case (req.addr)
        oneshot_pkg::ADDR_MODE: mode_q <= req.wdata;
        oneshot_pkg::ADDR_PULSE_MODE: pmode_q <= req.wdata;
        oneshot_pkg::ADDR_PRESCALER: presc_rld_q <= req.wdata;
        oneshot_pkg::ADDR_PRIMARY: prim_rld_q <= req.wdata;
        oneshot_pkg::ADDR_SECONDARY: sec_q <= req.wdata; // stored, never counted
        oneshot_pkg::ADDR_ONESHOT_CTRL: ;
        oneshot_pkg::ADDR_IRQ_PIN_EN: pin_en_q <= req.wdata[oneshot_pkg::IRQ_PIN_IN_EN_POS];
        oneshot_pkg::ADDR_CLK_SEL: src_q <= req.wdata[1:0];
      endcase
    end
  end

  // start bit: set by software or trigger, cleared on underflow; set wins
  always_ff @(posedge clk_in or negedge rstn_q)
  begin
    if (!rstn_q)
      start_bit_q <= 1'b0;
    else if (sw_start && mode_q[oneshot_pkg::START_FLAG_POS])
      start_bit_q <= 1'b1;
    else if (trig_edge && !running_q && mode_q[oneshot_pkg::START_FLAG_POS]
      && pmode_q[oneshot_pkg::TRIG_EN_POS])
      start_bit_q <= 1'b1;
    else if (req.wr && req.addr == oneshot_pkg::ADDR_ONESHOT_CTRL)
      start_bit_q <= 1'b0;
    else if (underflow)
      start_bit_q <= 1'b0;
  end

  // cascaded counters; reload on underflow and whenever idle
  always_ff @(posedge clk_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      presc_q <= oneshot_pkg::RESET_COUNT;
      prim_q <= oneshot_pkg::RESET_COUNT;
      running_q <= 1'b0;
    end
    else if (!running_q || underflow || stop_req || !mode_ok)
    begin
      presc_q <= presc_rld_q;
      prim_q <= prim_rld_q;
      running_q <= mode_ok && start_bit_q && !underflow
        && mode_q[oneshot_pkg::START_FLAG_POS];
    end
    else if (tick)
    begin
      if (presc_q == 8'h00)
      begin
        presc_q <= presc_rld_q;
        prim_q <= prim_q - 8'h01;
      end
      else
        presc_q <= presc_q - 8'h01;
    end
  end

  // irq and pulse end half a source cycle after underflow, one clock for f1 and neighbour
  always_ff @(posedge clk_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      irq_pend_q <= 1'b0;
      half_q <= 3'h0;
      timer_irq_out <= 1'b0;
    end
    else
    begin
      timer_irq_out <= 1'b0;
      if (underflow)
      begin
        irq_pend_q <= 1'b1;
        half_q <= 3'h1;
      end
      else if (irq_pend_q)
      begin
        half_q <= half_q + 3'h1;
        if (half_q + 3'h1 >= half_target)
        begin
          irq_pend_q <= 1'b0;
          timer_irq_out <= 1'b1;
        end
      end
    end
  end

  // output pin: active level while running or awaiting the half cycle
  always_ff @(posedge clk_in or negedge rstn_q)
  begin
    if (!rstn_q)
      pulse_out_pin_out <= 1'b0;
    else
      pulse_out_pin_out <= pmode_q[oneshot_pkg::LEVEL_SEL_POS] ^
        ((running_q && !stop_req && mode_ok) || (irq_pend_q && !(half_q + 3'h1 >= half_target)));
  end

  // read data one cycle after the strobe, live counts for counters
  always_ff @(posedge clk_in or negedge rstn_q)
  begin
    if (!rstn_q)
      rdata_out <= oneshot_pkg::RESET_BYTE;
    else if (req.rd)
      rdata_out <= rd_mux(req.addr, mode_q, pmode_q, presc_q, prim_q, sec_q,
        start_bit_q, pin_en_q, src_q);
    else
      rdata_out <= oneshot_pkg::RESET_BYTE;
  end

  // start bit falls back to 0 within a cycle of underflow
  AST_UF_CLEARS_START: assert property (@(posedge clk_in) disable iff (!rstn_q)
    underflow && !sw_start && !trig_edge |=> !start_bit_q)
    else $error("start bit not cleared after underflow");
  // primary counter equals its reload value one cycle after a stop
  AST_STOP_RELOADS: assert property (@(posedge clk_in) disable iff (!rstn_q)
    (running_q && stop_req && !req.wr) |=> (prim_q == $past(prim_rld_q)))
    else $error("counter not reloaded on stop");
  // timer irq follows underflow within the half cycle
  AST_IRQ_AFTER_UF: assert property (@(posedge clk_in) disable iff (!rstn_q)
    underflow |-> ##[1:4] timer_irq_out)
    else $error("timer irq missing after underflow");
  // pin irq raised for a trigger even while running
  AST_TRIG_IRQ: assert property (@(posedge clk_in) disable iff (!rstn_q)
    trig_edge |=> ext_irq_out)
    else $error("pin irq not raised");
  // a trigger during a count does not restart the counters
  AST_TRIG_IGNORED: assert property (@(posedge clk_in) disable iff (!rstn_q)
    (running_q && trig_edge && !underflow && !stop_req && mode_ok && !req.wr)
    |=> prim_q == $past(prim_q) - {7'h00, $past(tick && presc_q == 8'h00)})
    else $error("running count disturbed by trigger");
  // a primary write does not move the live counter
  AST_WRITE_RELOAD_ONLY: assert property (@(posedge clk_in) disable iff (!rstn_q)
    (running_q && !underflow && !stop_req && mode_ok && req.wr
    && req.addr == oneshot_pkg::ADDR_PRIMARY)
    |=> prim_q == $past(prim_q) - {7'h00, $past(tick && presc_q == 8'h00)})
    else $error("write disturbed live counter");
  // trigger disabled never starts a count
  AST_NO_TRIG_WHEN_OFF: assert property (@(posedge clk_in) disable iff (!rstn_q)
    (!pmode_q[oneshot_pkg::TRIG_EN_POS] && !start_bit_q && !(req.wr
    && req.addr == oneshot_pkg::ADDR_ONESHOT_CTRL)) |=> !start_bit_q)
    else $error("pin triggered while disabled");
  // prescaler wrap decrements primary once
  AST_CASCADE: assert property (@(posedge clk_in) disable iff (!rstn_q)
    (running_q && tick && !stop_req && mode_ok && presc_q == 8'h00 && prim_q != 8'h00)
    |=> prim_q == $past(prim_q) - 8'h01)
    else $error("cascade decrement wrong");
  // timer irq rises on the edge that returns the pin to idle
  AST_IRQ_AT_PULSE_END: assert property (@(posedge clk_in) disable iff (!rstn_q)
    timer_irq_out |-> pulse_out_pin_out == pmode_q[oneshot_pkg::LEVEL_SEL_POS])
    else $error("timer irq apart from pulse end");
endmodule

// ---- include/oneshot_pkg.sv ----
package oneshot_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_MODE = 3'h0; // timer_mode_reg
  localparam logic [2:0] ADDR_PULSE_MODE = 3'h1; // pulse_output_mode_reg
  localparam logic [2:0] ADDR_PRESCALER = 3'h2; // prescaler_counter
  localparam logic [2:0] ADDR_PRIMARY = 3'h3; // primary_period_counter
  localparam logic [2:0] ADDR_SECONDARY = 3'h4; // secondary_period_reg
  localparam logic [2:0] ADDR_ONESHOT_CTRL = 3'h5; // oneshot_control_reg
  localparam logic [2:0] ADDR_IRQ_PIN_EN = 3'h6; // irq_pin_enable_reg
  localparam logic [2:0] ADDR_CLK_SEL = 3'h7; // count source select
  // timer_mode_reg fields
  localparam int MODE_LO_POS = 4;
  localparam int MODE_HI_POS = 5;
  localparam int WRITE_CTRL_POS = 6;
  localparam int START_FLAG_POS = 7;
  localparam logic [1:0] MODE_ONESHOT = 2'h2;
  // pulse_output_mode_reg fields
  localparam int LEVEL_SEL_POS = 5;
  localparam int TRIG_EN_POS = 6;
  localparam int TRIG_POL_POS = 7;
  // oneshot_control_reg and irq_pin_enable_reg fields
  localparam int ONESHOT_START_POS = 0;
  localparam int IRQ_PIN_IN_EN_POS = 0;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_COUNT = 8'hFF;
  localparam logic [1:0] RESET_SRC = 2'h0;
  // count source choices
  typedef enum logic [1:0] {
    SRC_F1 = 2'h0,
    SRC_F2 = 2'h1,
    SRC_F8 = 2'h2,
    SRC_NEIGHBOUR = 2'h3
  } src_sel_t;
  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// ---- verification/ext_trigger_src.sv ----
`timescale 1ns/1ns
// drives the interrupt pin the way an outside trigger source would
module ext_trigger_src
(
  input wire logic clk_in,
  output logic pin_out
);
  // the pin has a pull-up, so it rests high between triggers
  initial pin_out = 1'b1;

  // one low pulse: a falling edge now and a rising edge n cycles later
  task automatic drop(input int n);
    @(posedge clk_in);
    pin_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    pin_out <= 1'b1;
  endtask
endmodule

// ---- verification/tb_one_shot_pulse_timer.sv ----
`timescale 1ns/1ns
module tb_one_shot_pulse_timer;
  // one table row: prescaler, period, count source, level select
  typedef struct packed {logic [7:0] ps; logic [7:0] pr; logic [1:0] src; logic lvl;} row_t;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic neighbour_uf_in = 1'b0;
  logic [1:0] nb_cnt = 2'h0; // neighbour underflow every third cycle
  logic ext_irq_pin;
  logic [7:0] rdata_out;
  logic pulse_pin;
  logic timer_irq;
  logic ext_irq;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_tirq = 0;
  int n_ext = 0;
  row_t rows [6] = '{'{8'h00, 8'h00, 2'h0, 1'b0}, '{8'h03, 8'h04, 2'h0, 1'b1},
    '{8'h01, 8'h02, 2'h1, 1'b0}, '{8'h02, 8'h01, 2'h2, 1'b1},
    '{8'h01, 8'h03, 2'h3, 1'b0}, '{8'h00, 8'hFF, 2'h0, 1'b0}};

  one_shot_pulse_timer uut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .neighbour_uf_in(neighbour_uf_in),
    .ext_irq_pin_in(ext_irq_pin), .rdata_out(rdata_out), .pulse_out_pin_out(pulse_pin),
    .timer_irq_out(timer_irq), .ext_irq_out(ext_irq));
  ext_trigger_src ext (.clk_in(clk_in), .pin_out(ext_irq_pin));

  // 10 MHz clock
  always #50 clk_in = ~clk_in;

  // neighbour timer source, interrupt counters and hang guard
  always @(posedge clk_in)
  begin
    nb_cnt <= (nb_cnt == 2'h2) ? 2'h0 : nb_cnt + 2'h1;
    neighbour_uf_in <= (nb_cnt == 2'h2);
    if (timer_irq === 1'b1) n_tirq++;
    if (ext_irq === 1'b1) n_ext++;
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      test_done();
    end
  end

  // verdict and end of run
  task automatic test_done();
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // compares a seen value with the expected one
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
  endtask

  // counts the clock cycles the pin spends at its active level
  task automatic measure(input logic act, output int w);
    int t;
    w = 0;
    t = 0;
    while (pulse_pin !== act && t < 30)
    begin
      @(negedge clk_in);
      t++;
    end
    while (pulse_pin === act && w < 5000)
    begin
      @(negedge clk_in);
      w++;
    end
  endtask

  // width within one source period of the expected figure
  function automatic logic [7:0] near(input int w, input int e, input int d);
    return {7'h0, (w >= e - d) && (w <= e + d)};
  endfunction

  initial
  begin
    logic [7:0] d;
    int w;
    int k;
    int dv;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(oneshot_pkg::ADDR_PRESCALER, d);
    check(d, 8'hFF);
    rd(oneshot_pkg::ADDR_PRIMARY, d);
    check(d, 8'hFF);
    check({7'h0, pulse_pin}, 8'h00);
    wr(oneshot_pkg::ADDR_IRQ_PIN_EN, 8'h01);
    // table of software-started pulses over sources and levels
    foreach (rows[i])
    begin
      dv = (rows[i].src == 2'h0) ? 1 : (rows[i].src == 2'h1) ? 2 : (rows[i].src == 2'h2) ? 8 : 3;
      wr(oneshot_pkg::ADDR_CLK_SEL, {6'h00, rows[i].src});
      wr(oneshot_pkg::ADDR_PULSE_MODE, {2'h0, rows[i].lvl, 5'h00});
      wr(oneshot_pkg::ADDR_PRESCALER, rows[i].ps);
      wr(oneshot_pkg::ADDR_PRIMARY, rows[i].pr);
      wr(oneshot_pkg::ADDR_MODE, 8'hE0);
      check({7'h0, pulse_pin}, {7'h0, rows[i].lvl});
      k = n_tirq;
      wr(oneshot_pkg::ADDR_ONESHOT_CTRL, 8'h01);
      measure(~rows[i].lvl, w);
      check(near(w, (int'(rows[i].ps) + 1) * (int'(rows[i].pr) + 1) * dv, dv), 8'h01);
      repeat (8) @(posedge clk_in);
      check(8'(n_tirq - k), 8'h01);
      rd(oneshot_pkg::ADDR_ONESHOT_CTRL, d);
      check({7'h0, d[0]}, 8'h00);
    end
    // period rewritten mid-pulse applies only to the next pulse
    wr(oneshot_pkg::ADDR_PRIMARY, 8'h13);
    wr(oneshot_pkg::ADDR_ONESHOT_CTRL, 8'h01);
    fork
      begin
        repeat (6) @(posedge clk_in);
        wr(oneshot_pkg::ADDR_PRIMARY, 8'h1D);
      end
    join_none
    measure(1'b1, w);
    check(near(w, 20, 1), 8'h01);
    wr(oneshot_pkg::ADDR_ONESHOT_CTRL, 8'h01);
    measure(1'b1, w);
    check(near(w, 30, 1), 8'h01);
    // stop by clearing the start bit, then by clearing the start flag
    wr(oneshot_pkg::ADDR_PRIMARY, 8'h63);
    for (int s = 0; s < 2; s++)
    begin
      wr(oneshot_pkg::ADDR_ONESHOT_CTRL, 8'h01);
      repeat (20) @(posedge clk_in);
      if (s == 0) wr(oneshot_pkg::ADDR_ONESHOT_CTRL, 8'h00);
      else wr(oneshot_pkg::ADDR_MODE, 8'h60);
      repeat (3) @(posedge clk_in);
      check({7'h0, pulse_pin}, 8'h00);
      rd(oneshot_pkg::ADDR_PRIMARY, d);
      check(d, 8'h63);
    end
    // start bit without the start flag gives no pulse
    wr(oneshot_pkg::ADDR_ONESHOT_CTRL, 8'h01);
    measure(1'b1, w);
    check(8'(w), 8'h00);
    // pin trigger, with a second edge landing mid-count
    wr(oneshot_pkg::ADDR_MODE, 8'hE0);
    wr(oneshot_pkg::ADDR_PRIMARY, 8'h27);
    wr(oneshot_pkg::ADDR_PULSE_MODE, 8'h40);
    k = n_ext;
    fork
      begin
        ext.drop(3);
        repeat (20) @(posedge clk_in);
        ext.drop(3);
      end
    join_none
    measure(1'b1, w);
    check(near(w, 40, 1), 8'h01);
    repeat (8) @(posedge clk_in);
    check(8'(n_ext - k), 8'h02);
    // trigger disabled: pin edge is only an interrupt
    wr(oneshot_pkg::ADDR_PULSE_MODE, 8'h00);
    k = n_ext;
    ext.drop(3);
    measure(1'b1, w);
    check(8'(w), 8'h00);
    check(8'(n_ext - k), 8'h01);
    // falling polarity: the pulse runs out while the pin is still low
    wr(oneshot_pkg::ADDR_PULSE_MODE, 8'hC0);
    k = n_tirq;
    ext.drop(50);
    check(8'(n_tirq - k), 8'h01);
    measure(1'b1, w);
    check(8'(w), 8'h00);
    // reset in mid-pulse puts the pin and the counters back to rest
    wr(oneshot_pkg::ADDR_ONESHOT_CTRL, 8'h01);
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({7'h0, pulse_pin}, 8'h00);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(oneshot_pkg::ADDR_PRIMARY, d);
    check(d, 8'hFF);
    test_done();
  end
endmodule
